// file: src/cdie_engine.sv
// Instruction engine of a character display controller
`timescale 1ns/1ps

// Summary of operation
// - Host transfers captured, then executed internally
// - Status read shows busy high while executing
// - Address counter steps after every RAM access
// - Clear fills spaces, zeroes address and cursor
// - Clear forces entry direction to increment
// - Home zeroes address, undoes shift, keeps RAM
// - Entry mode stores direction and auto scroll
// - Direction high increments, low decrements
// - Glyph RAM steps address the same way
// - No scroll on reads, glyph access, scroll off
// - Scrolled write shifts display per direction
// - Display control stores enable, cursor, blink
// - Shift moves cursor or display, RAM untouched
// - Function set picks width, lines and font
// - Glyph address set loads counter, selects glyph
// - Display address set loads counter, selects display
// - Status read returns busy and counter, instantly
// - Data write stores byte to selected RAM
// - Data read returns byte at the counter
// - Narrow bus moves bytes as two upper nibbles
// - Select chooses path, enable strobes transfers
// - Display disable blanks, RAM contents kept
module cdie_engine #(
	parameter int unsigned LONG_CYC = cdie_pkg::CYC_LONG
) (
	sys_clk,
	resetn,
	clk_en,
	reg_select,
	rd_wr,
	en_strobe,
	bus_lines_in,
	bus_lines_out,
	bus_lines_oe,
	busy_indicator,
	xfer_ready,
	addr_counter,
	glyph_sel,
	disp_shift,
	cfg
);
	input  wire logic         sys_clk;
	input  wire logic         resetn;
	input  wire logic         clk_en;
	input  wire logic         reg_select;
	input  wire logic         rd_wr;
	input  wire logic         en_strobe;
	input  wire logic [7:0]   bus_lines_in;
	output logic [7:0]        bus_lines_out;
	output logic              bus_lines_oe;
	output logic              busy_indicator;
	output logic              xfer_ready;
	output logic [6:0]        addr_counter;
	output logic              glyph_sel;
	output logic [6:0]        disp_shift;
	output cdie_pkg::cdie_cfg_t cfg;

	generate
		if (LONG_CYC <= (1 << cdie_pkg::DD_AW) ||
		    LONG_CYC >= (1 << cdie_pkg::CNT_W)) begin : g_bad
			$error("LONG_CYC must exceed the clear sweep and fit the counter");
		end
	endgenerate

	localparam logic [cdie_pkg::CNT_W-1:0] LONG_LD =
		cdie_pkg::CNT_W'(LONG_CYC - 1);
	localparam logic [cdie_pkg::CNT_W-1:0] MID_LD =
		cdie_pkg::CNT_W'(cdie_pkg::CYC_MID - 1);
	localparam logic [cdie_pkg::CNT_W-1:0] DATA_LD =
		cdie_pkg::CNT_W'(cdie_pkg::CYC_DATA - 1);
	localparam logic [cdie_pkg::CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [6:0] SWEEP_LAST = 7'h7F;

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0]  dd_ram [1 << cdie_pkg::DD_AW];
	logic [7:0]  cg_ram [1 << cdie_pkg::CG_AW];
	logic        en_q;
	logic        phase_q;
	logic [3:0]  hold_hi_q;
	logic        push_q;
	cdie_pkg::cdie_xfer_t push_data_q;
	logic        buf_ready;
	logic        buf_valid;
	cdie_pkg::cdie_xfer_t head;
	cdie_pkg::cdie_state_t state_q;
	logic [cdie_pkg::CNT_W-1:0] cnt_q;
	logic [6:0]  sweep_q;
	logic [6:0]  ac_q;
	logic        glyph_q;
	logic [6:0]  shift_q;
	cdie_pkg::cdie_cfg_t cfg_q;
	logic        busy_q;
	logic        pop;
	logic        op_fs;

	// ****************************************************************
	// Host strobe capture
	// ****************************************************************
	logic        rise;
	logic        fall;
	logic        narrow;
	logic        last_nib;
	logic [7:0]  rd_byte;
	logic [7:0]  stat_byte;
	logic [7:0]  out_byte;
	logic [7:0]  full_byte;

	assign rise      = en_strobe && !en_q;
	assign fall      = !en_strobe && en_q;
	assign narrow    = !cfg_q.bus_width;
	assign last_nib  = !narrow || phase_q;
	assign rd_byte   = glyph_q ? cg_ram[ac_q[cdie_pkg::CG_AW-1:0]]
	                           : dd_ram[ac_q];
	assign stat_byte = {busy_q, ac_q};
	assign out_byte  = reg_select ? rd_byte : stat_byte;
	assign full_byte = narrow
		? {hold_hi_q, bus_lines_in[cdie_pkg::NIB_HI:cdie_pkg::NIB_LO]}
		: bus_lines_in;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			en_q <= 1'b0;
		end else if (clk_en) begin
			en_q <= en_strobe;
		end
	end

	// Reads drive on the rising strobe and release on the falling one
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bus_lines_out <= cdie_pkg::BYTE_ZERO;
			bus_lines_oe  <= 1'b0;
		end else if (clk_en) begin
			if (rise && rd_wr) begin
				bus_lines_oe <= 1'b1;
				if (!narrow) begin
					bus_lines_out <= out_byte;
				end else if (!phase_q) begin
					bus_lines_out <= {out_byte[7:4], cdie_pkg::NIB_ZERO};
				end else begin
					bus_lines_out <= {out_byte[3:0], cdie_pkg::NIB_ZERO};
				end
			end else if (fall) begin
				bus_lines_oe <= 1'b0;
			end
		end
	end

	// Nibble phase; a function set restarts on the upper nibble
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			phase_q   <= 1'b0;
			hold_hi_q <= cdie_pkg::NIB_ZERO;
		end else if (clk_en) begin
			if (op_fs) begin
				phase_q <= 1'b0;
			end else if (fall && narrow) begin
				phase_q <= ~phase_q;
				if (!phase_q) begin
					hold_hi_q <= bus_lines_in[cdie_pkg::NIB_HI:cdie_pkg::NIB_LO];
				end
			end
		end
	end

	// Whole bytes go to the holding buffer, status reads do not
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			push_q      <= 1'b0;
			push_data_q <= '0;
		end else if (clk_en) begin
			push_q <= 1'b0;
			if (fall && last_nib && (!rd_wr || reg_select) && !push_q) begin
				push_q             <= 1'b1;
				push_data_q.sel    <= reg_select;
				push_data_q.rd     <= rd_wr;
				push_data_q.byte_v <= full_byte;
			end
		end
	end

	// A host ignoring busy while both entries are full is dropped
	cdie_buf #(
		.DEPTH (2)
	) u_buf (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.clk_en    (clk_en),
		.in_valid  (push_q),
		.in_ready  (buf_ready),
		.in_data   (push_data_q),
		.out_valid (buf_valid),
		.out_ready (pop),
		.out_data  (head)
	);

	// ****************************************************************
	// Decode
	// ****************************************************************
	logic       is_wr;
	logic       is_rd;
	logic       is_ins;
	logic       op_dd;
	logic       op_cg;
	logic       op_sh;
	logic       op_dc;
	logic       op_em;
	logic       op_home;
	logic       op_clr;
	logic [7:0] b;

	assign b       = head.byte_v;
	assign pop     = (state_q == cdie_pkg::CDIE_IDLE) && buf_valid;
	assign is_ins  = pop && !head.sel;
	assign is_wr   = pop && head.sel && !head.rd;
	assign is_rd   = pop && head.sel && head.rd;
	assign op_dd   = is_ins && b[cdie_pkg::B_DD];
	assign op_cg   = is_ins && (b[7:6] == cdie_pkg::PFX_CG);
	assign op_fs   = is_ins && (b[7:5] == cdie_pkg::PFX_FS);
	assign op_sh   = is_ins && (b[7:4] == cdie_pkg::PFX_SH);
	assign op_dc   = is_ins && (b[7:3] == cdie_pkg::PFX_DC);
	assign op_em   = is_ins && (b[7:2] == cdie_pkg::PFX_EM);
	assign op_home = is_ins && (b[7:1] == cdie_pkg::PFX_HOME);
	assign op_clr  = is_ins && (b == cdie_pkg::OPC_CLEAR);

	function automatic logic [6:0] step(input logic [6:0] a,
	                                    input logic       up,
	                                    input logic       gly);
		logic [6:0] n;
		n = up ? a + cdie_pkg::ONE7 : a - cdie_pkg::ONE7;
		if (gly) begin
			n[cdie_pkg::DD_AW-1] = 1'b0;
		end
		return n;
	endfunction

	// ****************************************************************
	// Execution timing
	// ****************************************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= cdie_pkg::CDIE_IDLE;
			cnt_q   <= CNT_ZERO;
			sweep_q <= cdie_pkg::HOME_ADDR;
		end else if (clk_en) begin
			unique case (state_q)
				cdie_pkg::CDIE_IDLE: begin
					if (op_clr) begin
						state_q <= cdie_pkg::CDIE_CLEAR;
						cnt_q   <= LONG_LD;
						sweep_q <= cdie_pkg::HOME_ADDR;
					end else if (op_home) begin
						state_q <= cdie_pkg::CDIE_WAIT;
						cnt_q   <= LONG_LD;
					end else if (is_wr || is_rd) begin
						state_q <= cdie_pkg::CDIE_WAIT;
						cnt_q   <= DATA_LD;
					end else if (is_ins && b != cdie_pkg::BYTE_ZERO) begin
						state_q <= cdie_pkg::CDIE_WAIT;
						cnt_q   <= MID_LD;
					end
				end
				cdie_pkg::CDIE_CLEAR: begin
					cnt_q   <= cnt_q - 1'b1;
					sweep_q <= sweep_q + cdie_pkg::ONE7;
					if (sweep_q == SWEEP_LAST) begin
						state_q <= cdie_pkg::CDIE_WAIT;
					end
				end
				cdie_pkg::CDIE_WAIT: begin
					cnt_q <= cnt_q - 1'b1;
					if (cnt_q == CNT_ZERO) begin
						state_q <= cdie_pkg::CDIE_IDLE;
					end
				end
				default: begin
					state_q <= cdie_pkg::CDIE_IDLE;
				end
			endcase
		end
	end

	// Queued work counts as busy so a polling host never overruns
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			busy_q     <= 1'b0;
			xfer_ready <= 1'b1;
		end else if (clk_en) begin
			busy_q     <= (state_q != cdie_pkg::CDIE_IDLE) || buf_valid ||
			              push_q;
			xfer_ready <= buf_ready;
		end
	end

	// ****************************************************************
	// RAM writes
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			if (state_q == cdie_pkg::CDIE_CLEAR) begin
				dd_ram[sweep_q] <= cdie_pkg::SPACE_CODE;
			end else if (is_wr && !glyph_q) begin
				dd_ram[ac_q] <= b;
			end
			if (is_wr && glyph_q) begin
				cg_ram[ac_q[cdie_pkg::CG_AW-1:0]] <= b;
			end
		end
	end

	// ****************************************************************
	// Address counter and display shift
	// ****************************************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ac_q    <= cdie_pkg::HOME_ADDR;
			glyph_q <= 1'b0;
		end else if (clk_en) begin
			if (op_clr || op_home) begin
				ac_q    <= cdie_pkg::HOME_ADDR;
				glyph_q <= 1'b0;
			end else if (op_dd) begin
				ac_q    <= b[6:0];
				glyph_q <= 1'b0;
			end else if (op_cg) begin
				ac_q    <= {1'b0, b[cdie_pkg::CG_AW-1:0]};
				glyph_q <= 1'b1;
			end else if (is_wr || is_rd) begin
				ac_q <= step(ac_q, cfg_q.entry_incr, glyph_q);
			end else if (op_sh && !b[cdie_pkg::B_SC]) begin
				ac_q <= step(ac_q, b[cdie_pkg::B_RL], glyph_q);
			end
		end
	end

	// Left scroll counts up; the view pans with the offset
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			shift_q <= cdie_pkg::SHIFT_ZERO;
		end else if (clk_en) begin
			if (op_clr || op_home) begin
				shift_q <= cdie_pkg::SHIFT_ZERO;
			end else if (is_wr && !glyph_q && cfg_q.auto_scroll) begin
				shift_q <= cfg_q.entry_incr ? shift_q + cdie_pkg::ONE7
				                            : shift_q - cdie_pkg::ONE7;
			end else if (op_sh && b[cdie_pkg::B_SC]) begin
				shift_q <= b[cdie_pkg::B_RL] ? shift_q - cdie_pkg::ONE7
				                             : shift_q + cdie_pkg::ONE7;
			end
		end
	end

	// ****************************************************************
	// Configuration
	// ****************************************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q <= cdie_pkg::CFG_RESET;
		end else if (clk_en) begin
			if (op_clr) begin
				cfg_q.entry_incr <= 1'b1;
			end
			if (op_em) begin
				cfg_q.entry_incr  <= b[cdie_pkg::B_ID];
				cfg_q.auto_scroll <= b[cdie_pkg::B_SHE];
			end
			if (op_dc) begin
				cfg_q.disp_on   <= b[cdie_pkg::B_D];
				cfg_q.cursor_on <= b[cdie_pkg::B_C];
				cfg_q.blink_on  <= b[cdie_pkg::B_B];
			end
			if (op_fs) begin
				cfg_q.bus_width <= b[cdie_pkg::B_DL];
				cfg_q.two_line  <= b[cdie_pkg::B_N];
				cfg_q.font_big  <= b[cdie_pkg::B_F];
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign busy_indicator = busy_q;
	assign addr_counter   = ac_q;
	assign glyph_sel      = glyph_q;
	assign disp_shift     = shift_q;
	assign cfg            = cfg_q;

endmodule

// file: src/cdie_pkg.sv
// Shared constants and types for the character display instruction engine
package cdie_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_NS      = 20;
	localparam int unsigned T_LONG_NS   = 1530000;
	localparam int unsigned T_MID_NS    = 39000;
	localparam int unsigned T_DATA_NS   = 43000;
	// Busy times are least times, so round up
	localparam int unsigned CYC_LONG    = (T_LONG_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_MID     = (T_MID_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_DATA    = (T_DATA_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CNT_W       = 17;

	// ****************************************************************
	// Widths, codes and reset values
	// ****************************************************************
	localparam int unsigned DW          = 8;
	localparam int unsigned DD_AW       = 7;
	localparam int unsigned CG_AW       = 6;
	localparam int unsigned NIB_HI      = 7;
	localparam int unsigned NIB_LO      = 4;
	localparam logic [7:0]  SPACE_CODE  = 8'h20;
	localparam logic [6:0]  HOME_ADDR   = 7'h00;
	localparam logic [6:0]  SHIFT_ZERO  = 7'h00;
	localparam logic [6:0]  ONE7        = 7'h01;
	localparam logic [7:0]  BYTE_ZERO   = 8'h00;
	localparam logic [3:0]  NIB_ZERO    = 4'h0;
	localparam logic [7:0]  OPC_CLEAR   = 8'h01;

	// Instruction prefixes, leading one selects the group
	localparam logic [1:0]  PFX_CG      = 2'h1;
	localparam logic [2:0]  PFX_FS      = 3'h1;
	localparam logic [3:0]  PFX_SH      = 4'h1;
	localparam logic [4:0]  PFX_DC      = 5'h01;
	localparam logic [5:0]  PFX_EM      = 6'h01;
	localparam logic [6:0]  PFX_HOME    = 7'h01;

	// Field positions
	localparam int unsigned B_DD        = 7;
	localparam int unsigned B_BUSY      = 7;
	localparam int unsigned B_DL        = 4;
	localparam int unsigned B_N         = 3;
	localparam int unsigned B_F         = 2;
	localparam int unsigned B_SC        = 3;
	localparam int unsigned B_RL        = 2;
	localparam int unsigned B_D         = 2;
	localparam int unsigned B_C         = 1;
	localparam int unsigned B_B         = 0;
	localparam int unsigned B_ID        = 1;
	localparam int unsigned B_SHE       = 0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic       sel;
		logic       rd;
		logic [7:0] byte_v;
	} cdie_xfer_t;

	typedef struct packed {
		logic disp_on;
		logic cursor_on;
		logic blink_on;
		logic bus_width;
		logic two_line;
		logic font_big;
		logic entry_incr;
		logic auto_scroll;
	} cdie_cfg_t;

	// Power-up: 8-bit bus, increment, all else off
	localparam cdie_cfg_t CFG_RESET = '{
		disp_on: 1'b0, cursor_on: 1'b0, blink_on: 1'b0, bus_width: 1'b1,
		two_line: 1'b0, font_big: 1'b0, entry_incr: 1'b1,
		auto_scroll: 1'b0};

	typedef enum logic [1:0] {
		CDIE_IDLE  = 2'b00,
		CDIE_WAIT  = 2'b01,
		CDIE_CLEAR = 2'b10
	} cdie_state_t;

endpackage

// file: src/cdie_buf.sv
// Two-entry transfer buffer between host capture and the executor
`timescale 1ns/1ps
module cdie_buf #(
	parameter int unsigned DEPTH = 2
) (
	sys_clk,
	resetn,
	clk_en,
	in_valid,
	in_ready,
	in_data,
	out_valid,
	out_ready,
	out_data
);
	input  wire logic                sys_clk;
	input  wire logic                resetn;
	input  wire logic                clk_en;
	input  wire logic                in_valid;
	output logic                     in_ready;
	input  wire cdie_pkg::cdie_xfer_t in_data;
	output logic                     out_valid;
	input  wire logic                out_ready;
	output cdie_pkg::cdie_xfer_t     out_data;

	// ****************************************************************
	// Storage
	// ****************************************************************
	generate
		if (DEPTH != 2) begin : g_bad
			$error("cdie_buf supports exactly two entries");
		end
	endgenerate

	cdie_pkg::cdie_xfer_t mem_q [DEPTH];
	logic                 wr_ptr_q;
	logic                 rd_ptr_q;
	logic [1:0]           count_q;
	logic                 push;
	logic                 pop;

	assign in_ready  = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data  = mem_q[rd_ptr_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge sys_clk) begin
		if (clk_en && push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule

// file: dv/cdie_engine_chk.sv
// Port checker for the display instruction engine
`timescale 1ns/1ps
module cdie_engine_chk #(
	parameter int unsigned LONG_CYC = cdie_pkg::CYC_LONG
) (
	input wire logic                sys_clk,
	input wire logic                resetn,
	input wire logic                clk_en,
	input wire logic                reg_select,
	input wire logic                rd_wr,
	input wire logic                en_strobe,
	input wire logic [7:0]          bus_lines_in,
	input wire logic [7:0]          bus_lines_out,
	input wire logic                bus_lines_oe,
	input wire logic                busy_indicator,
	input wire logic                xfer_ready,
	input wire logic [6:0]          addr_counter,
	input wire logic                glyph_sel,
	input wire logic [6:0]          disp_shift,
	input wire cdie_pkg::cdie_cfg_t cfg
);
	// ****************************************************************
	// Helper logic
	// ****************************************************************
	// Clear and home share the long time; the floor is the shorter of it and the mid time
	localparam int unsigned MIN_BUSY = (LONG_CYC < cdie_pkg::CYC_MID) ?
		LONG_CYC : cdie_pkg::CYC_MID;
	logic        en_q;
	logic        clr_q;
	logic        home_q;
	logic [16:0] busy_cnt_q;
	logic        rise;
	logic        iwr;
	logic        done;
	assign rise = en_strobe & ~en_q;
	// Byte decode only valid on the wide bus
	assign iwr  = ~en_strobe & en_q & ~reg_select & ~rd_wr & cfg.bus_width;
	assign done = ~busy_indicator & (busy_cnt_q != 17'h00000);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			en_q   <= 1'b0;
			clr_q  <= 1'b0;
			home_q <= 1'b0;
		end else begin
			en_q <= en_strobe;
			if (iwr) begin
				clr_q  <= bus_lines_in == cdie_pkg::OPC_CLEAR;
				home_q <= bus_lines_in[7:1] == cdie_pkg::PFX_HOME;
			end else if (done) begin
				clr_q  <= 1'b0;
				home_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) busy_cnt_q <= 17'h00000;
		else if (busy_indicator) busy_cnt_q <= busy_cnt_q + 17'h00001;
		else busy_cnt_q <= 17'h00000;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_status_busy: assert property (@(posedge sys_clk) disable iff (!resetn)
		(rise && !reg_select && rd_wr && cfg.bus_width && busy_indicator)
		##1 busy_indicator |-> bus_lines_out[7])
		else $error("status bit 7 low while busy");
	a_status_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
		(rise && !reg_select && rd_wr && cfg.bus_width && !busy_indicator)
		##1 !busy_indicator |-> bus_lines_out[6:0] == addr_counter)
		else $error("status read lost the address");
	a_oe_read: assert property (@(posedge sys_clk) disable iff (!resetn)
		rise && rd_wr |=> bus_lines_oe) else $error("read not driven");
	a_oe_write: assert property (@(posedge sys_clk) disable iff (!resetn)
		rise && !rd_wr |=> !bus_lines_oe) else $error("bus driven on write");
	a_busy_min: assert property (@(posedge sys_clk) disable iff (!resetn)
		$fell(busy_indicator) |-> busy_cnt_q >= MIN_BUSY)
		else $error("busy dropped too early");
	a_clear_done: assert property (@(posedge sys_clk) disable iff (!resetn)
		clr_q && done |-> addr_counter == cdie_pkg::HOME_ADDR && cfg.entry_incr)
		else $error("clear left address or direction");
	a_home_done: assert property (@(posedge sys_clk) disable iff (!resetn)
		home_q && done |-> addr_counter == cdie_pkg::HOME_ADDR &&
		disp_shift == cdie_pkg::SHIFT_ZERO) else $error("home incomplete");
	a_addr_busy: assert property (@(posedge sys_clk) disable iff (!resetn)
		$changed(addr_counter) |-> ##[0:2] busy_indicator)
		else $error("address moved with no operation");
	a_nib_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
		rise && rd_wr && !cfg.bus_width |=> bus_lines_out[3:0] == 4'h0)
		else $error("low lines not zero on narrow read");
	a_ready_busy: assert property (@(posedge sys_clk) disable iff (!resetn)
		!xfer_ready |-> busy_indicator) else $error("full buffer but idle");
endmodule

bind cdie_engine cdie_engine_chk #(.LONG_CYC(LONG_CYC)) i_cdie_engine_chk (
	.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
	.reg_select(reg_select), .rd_wr(rd_wr), .en_strobe(en_strobe),
	.bus_lines_in(bus_lines_in), .bus_lines_out(bus_lines_out),
	.bus_lines_oe(bus_lines_oe), .busy_indicator(busy_indicator),
	.xfer_ready(xfer_ready), .addr_counter(addr_counter),
	.glyph_sel(glyph_sel), .disp_shift(disp_shift), .cfg(cfg));

// file: dv/cdie_host.sv
// Host processor model on the parallel bus
`timescale 1ns/1ps
module cdie_host (
	input wire logic        sys_clk,
	output logic            reg_select,
	output logic            rd_wr,
	output logic            en_strobe,
	output logic [7:0]      bus_lines_in,
	input wire logic [7:0]  bus_lines_out
);
	initial begin
		reg_select   = 1'b0;
		rd_wr        = 1'b0;
		en_strobe    = 1'b0;
		bus_lines_in = 8'h00;
	end

	// One strobe: select and data held until after the falling sample
	task automatic xfer(input logic sel, input logic rd, input logic [7:0] wd,
		output logic [7:0] rdat);
		@(posedge sys_clk);
		#1;
		reg_select   = sel;
		rd_wr        = rd;
		bus_lines_in = wd;
		en_strobe    = 1'b1;
		repeat (2) @(posedge sys_clk);
		rdat = bus_lines_out;
		#1;
		en_strobe = 1'b0;
		@(posedge sys_clk);
		#1;
		// Released lines have no pull, so never show the old value
		bus_lines_in = ~wd;
	endtask

	// Narrow bus: upper half first on the top four lines
	task automatic xfer4(input logic sel, input logic rd, input logic [7:0] wd,
		output logic [7:0] rdat);
		logic [7:0] h;
		logic [7:0] l;
		xfer(sel, rd, {wd[7:4], 4'h5}, h);
		xfer(sel, rd, {wd[3:0], 4'hA}, l);
		rdat = {h[7:4], l[7:4]};
	endtask
endmodule

// file: dv/cdie_engine_bench.sv
// Self-checking bench for the display instruction engine
`timescale 1ns/1ps
module cdie_engine_bench;
	// Short long-op time keeps the run small; must exceed the 128 sweep
	localparam int unsigned LONG_T   = 200;
	localparam int unsigned HALF_OSC = 93;
	localparam int unsigned LIMIT    = 95000;
	logic                sys_clk = 1'b0;
	logic                resetn = 1'b0;
	logic                clk_en = 1'b1;
	logic                four = 1'b0;
	wire logic           reg_select;
	wire logic           rd_wr;
	wire logic           en_strobe;
	wire logic [7:0]     bus_lines_in;
	logic [7:0]          bus_lines_out;
	logic                bus_lines_oe;
	logic                busy_indicator;
	logic                xfer_ready;
	logic [6:0]          addr_counter;
	logic                glyph_sel;
	logic [6:0]          disp_shift;
	cdie_pkg::cdie_cfg_t cfg;
	int                  mismatches = 0;
	int                  checks = 0;
	int                  cycles = 0;

	always #10 sys_clk = ~sys_clk;

	cdie_engine #(.LONG_CYC(LONG_T)) i_cdie_engine (.sys_clk(sys_clk),
		.resetn(resetn), .clk_en(clk_en), .reg_select(reg_select),
		.rd_wr(rd_wr), .en_strobe(en_strobe), .bus_lines_in(bus_lines_in),
		.bus_lines_out(bus_lines_out), .bus_lines_oe(bus_lines_oe),
		.busy_indicator(busy_indicator), .xfer_ready(xfer_ready),
		.addr_counter(addr_counter), .glyph_sel(glyph_sel),
		.disp_shift(disp_shift), .cfg(cfg));
	cdie_host i_cdie_host (.sys_clk(sys_clk), .reg_select(reg_select),
		.rd_wr(rd_wr), .en_strobe(en_strobe), .bus_lines_in(bus_lines_in),
		.bus_lines_out(bus_lines_out));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic results();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic cac(input logic [7:0] exp);
		chk({glyph_sel, addr_counter}, exp);
	endtask

	task automatic op(input logic sel, input logic rd, input logic [7:0] b,
		output logic [7:0] r);
		if (four) i_cdie_host.xfer4(sel, rd, b, r);
		else i_cdie_host.xfer(sel, rd, b, r);
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic idle();
		logic [7:0] r;
		int         n;
		r = 8'h80;
		n = 0;
		while (r[7] !== 1'b0 && n < 3000) begin
			op(1'b0, 1'b1, 8'h00, r);
			n++;
		end
		chk({7'h00, r[7]}, 8'h00);
		repeat (HALF_OSC) @(posedge sys_clk);
	endtask

	task automatic go(input logic sel, input logic [7:0] b);
		logic [7:0] r;
		op(sel, 1'b0, b, r);
		idle();
	endtask

	task automatic rdd(output logic [7:0] r);
		op(1'b1, 1'b1, 8'h00, r);
		idle();
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		logic [7:0] r;
		chk(cfg, cdie_pkg::CFG_RESET);
		cac(8'h00);
		chk({busy_indicator, xfer_ready, bus_lines_oe, disp_shift[0], 4'h0},
			8'h40);
		// Frozen clock enable must ignore a whole strobe
		clk_en = 1'b0;
		op(1'b0, 1'b0, 8'h85, r);
		cac(8'h00);
		#1;
		clk_en = 1'b1;
	endtask

	task automatic t_busy();
		logic [7:0] r;
		op(1'b0, 1'b0, 8'h85, r);
		op(1'b0, 1'b1, 8'h00, r);
		chk({7'h00, r[7]}, 8'h01);
		idle();
		op(1'b0, 1'b1, 8'h00, r);
		chk(r, 8'h05);
	endtask

	task automatic t_data();
		logic [7:0] r;
		go(1'b1, 8'h41);
		cac(8'h06);
		go(1'b0, 8'h85);
		rdd(r);
		chk(r, 8'h41);
		cac(8'h06);
		go(1'b0, 8'h04);
		go(1'b1, 8'h42);
		cac(8'h05);
		go(1'b0, 8'h01);
		cac(8'h00);
		chk({7'h00, cfg.entry_incr}, 8'h01);
		go(1'b0, 8'h85);
		rdd(r);
		chk(r, 8'h20);
	endtask

	task automatic t_scroll();
		logic [7:0] r;
		go(1'b0, 8'h07);
		go(1'b1, 8'h55);
		chk({1'b0, disp_shift}, 8'h01);
		rdd(r);
		chk({1'b0, disp_shift}, 8'h01);
		go(1'b0, 8'h05);
		go(1'b1, 8'h56);
		chk({1'b0, disp_shift}, 8'h00);
		go(1'b0, 8'h07);
		go(1'b1, 8'h57);
		go(1'b0, 8'h02);
		cac(8'h00);
		chk({1'b0, disp_shift}, 8'h00);
		go(1'b0, 8'h50);
		cac(8'h90);
		go(1'b1, 8'h1F);
		cac(8'h91);
		chk({1'b0, disp_shift}, 8'h00);
		go(1'b0, 8'h50);
		rdd(r);
		chk(r, 8'h1F);
	endtask

	task automatic t_ctl();
		go(1'b0, 8'h80);
		go(1'b0, 8'h14);
		cac(8'h01);
		go(1'b0, 8'h10);
		cac(8'h00);
		go(1'b0, 8'h18);
		chk({1'b0, disp_shift}, 8'h01);
		go(1'b0, 8'h1C);
		chk({1'b0, disp_shift}, 8'h00);
		go(1'b0, 8'h0D);
		chk({5'h00, cfg[7:5]}, 8'h05);
		go(1'b0, 8'h0A);
		chk({5'h00, cfg[7:5]}, 8'h02);
		go(1'b0, 8'h3C);
		chk({5'h00, cfg[4:2]}, 8'h07);
	endtask

	task automatic t_narrow();
		logic [7:0] r;
		// Width changes at once, so poll in the new width
		op(1'b0, 1'b0, 8'h20, r);
		four = 1'b1;
		idle();
		chk({7'h00, cfg.bus_width}, 8'h00);
		go(1'b0, 8'hC5);
		op(1'b0, 1'b1, 8'h00, r);
		chk(r, 8'h45);
		op(1'b0, 1'b0, 8'h30, r);
		four = 1'b0;
		idle();
		op(1'b0, 1'b1, 8'h00, r);
		chk(r, 8'h45);
	endtask

	task automatic t_buffer();
		logic [7:0] r;
		go(1'b0, 8'h80);
		// Writes after the first break the polling rule on purpose; the fourth finds the buffer full
		for (int i = 0; i < 4; i++) begin
			op(1'b1, 1'b0, 8'h60 + 8'(i), r);
			if (i == 2) chk({7'h00, xfer_ready}, 8'h00);
		end
		idle();
		cac(8'h03);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			results();
		end
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		t_reset();
		t_busy();
		t_data();
		t_scroll();
		t_ctl();
		t_narrow();
		t_buffer();
		results();
	end
endmodule
